//--- dv/port_host.sv
`timescale 1ns/100ps
// ********
// Host on one data port.
// ********
module port_host
    import fifo_port_pkg::*;
#(
    parameter bit INV_DIR = 1'b0
)(
    // Clock.
    input  wire logic              clk,
    // Port controls and data.
    output logic                   select_n,
    output logic                   write_read,
    output logic                   enable,
    output logic                   mail_select,
    output logic      [DATA_W-1:0] data_in
);
    // Idle port at time zero.
    initial begin
        select_n = 1'b1;
        write_read = INV_DIR;
        enable = 1'b0;
        mail_select = 1'b0;
        data_in = '0;
    end

    // One transfer, taken at the second edge; released data shows the inverse word.
    task automatic xfer(logic wr, logic [DATA_W-1:0] d, logic en, logic mb);
        @(posedge clk);
        select_n <= 1'b0;
        write_read <= wr ^ INV_DIR;
        enable <= en;
        mail_select <= mb;
        data_in <= d;
        @(posedge clk);
        select_n <= 1'b1;
        enable <= 1'b0;
        data_in <= ~d;
    endtask

    // Sets select and direction pins with no transfer enabled.
    task automatic park(logic s, logic w);
        @(posedge clk);
        select_n <= s;
        write_read <= w;
        enable <= 1'b0;
    endtask
endmodule

//--- dv/tb_dual_clock_fifo_port_flags.sv
`timescale 1ns/100ps
// ********
// Bench for the port and flag logic.
// ********
module tb_dual_clock_fifo_port_flags
    import fifo_port_pkg::*;
;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err, strap;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              a_sn, a_wr, a_en, a_mb, a_oe_n, a_sp, a_df, a_lf;
    logic              b_sn, b_wr, b_en, b_mb, b_oe_n, b_sp, b_df, b_lf;
    logic [DATA_W-1:0] a_din, a_dout, b_din, b_dout;
    int                num_errors = 0;
    int                checked = 0;
    logic [DATA_W-1:0] rows [4] = '{36'h0_0000_0001, 36'hf_ffff_fffe, 36'h5_a5a5_a5a5, 36'h0};

    // Clock at 50 MHz.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    dual_clock_fifo_port_flags u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .endian_timing_select(strap),
        .first_port_select_n(a_sn), .first_port_write_read(a_wr), .first_port_enable(a_en),
        .first_port_mail_select(a_mb), .first_port_data_in(a_din),
        .first_port_data_out(a_dout), .first_port_data_oe_n(a_oe_n),
        .first_port_space_flag(a_sp), .first_port_data_flag(a_df),
        .first_port_low_fill_flag(a_lf), .second_port_select_n(b_sn),
        .second_port_write_read_inv(b_wr), .second_port_enable(b_en),
        .second_port_mail_select(b_mb), .second_port_data_in(b_din),
        .second_port_data_out(b_dout), .second_port_data_oe_n(b_oe_n),
        .second_port_space_flag(b_sp), .second_port_data_flag(b_df),
        .second_port_low_fill_flag(b_lf));
    port_host #(.INV_DIR(1'b0)) u_host_a (.clk(pclk), .select_n(a_sn), .write_read(a_wr),
        .enable(a_en), .mail_select(a_mb), .data_in(a_din));
    port_host #(.INV_DIR(1'b1)) u_host_b (.clk(pclk), .select_n(b_sn), .write_read(b_wr),
        .enable(b_en), .mail_select(b_mb), .data_in(b_din));

    task automatic check_bit(string n, logic e, logic g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %b, seen %b", n, e, g);
        end
    endtask

    task automatic check_word(string n, logic [DATA_W-1:0] e, logic [DATA_W-1:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("errors %0d, checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // One register transfer; the wait for pready is bounded.
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        if (n >= 16) begin
            num_errors++;
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset(logic s);
        presetn <= 1'b0;
        strap <= s;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    task automatic step();
        @(posedge pclk);
        @(negedge pclk);
    endtask

    // Main sequence.
    initial begin
        {psel, penable, pwrite, presetn, strap} = 5'h01;
        paddr = '0;
        pwdata = '0;
        do_reset(1'b1);
        apb(1'b0, 12'h000, 32'h0);
        check_word("offsets", 36'h0_0008_0008, {4'h0, rd});
        apb(1'b0, 12'h004, 32'h0);
        check_word("status", 36'h32, {4'h0, rd});
        check_bit("b_space", 1'b1, b_sp);
        check_bit("a_low", 1'b0, a_lf);
        check_bit("pready", 1'b1, pready);
        apb(1'b0, 12'h008, 32'h0);
        check_bit("pslverr", 1'b1, err);
        check_word("unmapped", 36'h0, {4'h0, rd});
        apb(1'b1, 12'h000, 32'h0003_0008);
        apb(1'b0, 12'h000, 32'h0);
        check_word("offsets", 36'h0_0003_0008, {4'h0, rd});
        for (int i = 0; i < 4; i++) begin
            u_host_a.park(i[1], i[0]);
            u_host_b.park(i[1], i[0]);
            @(negedge pclk);
            check_bit("oe_a", i[1] | i[0], a_oe_n);
            check_bit("oe_b", i[1] | !i[0], b_oe_n);
        end
        foreach (rows[r]) begin
            fork
                u_host_a.xfer(1'b1, rows[r], 1'b1, 1'b0);
                u_host_b.xfer(1'b1, ~rows[r], 1'b1, 1'b0);
            join
            repeat (2) @(posedge pclk);
            fork
                u_host_a.xfer(1'b0, '0, 1'b1, 1'b0);
                u_host_b.xfer(1'b0, '0, 1'b1, 1'b0);
            join
            @(negedge pclk);
            check_word("b_out", rows[r], b_dout);
            check_word("a_out", ~rows[r], a_dout);
        end
        u_host_a.xfer(1'b1, 36'h1, 1'b0, 1'b0);
        u_host_a.xfer(1'b1, 36'h2, 1'b1, 1'b1);
        u_host_b.xfer(1'b0, '0, 1'b1, 1'b0);
        repeat (3) step();
        check_bit("b_flag", 1'b0, b_df);
        check_word("b_out", 36'h0, b_dout);
        for (int i = 0; i < DEPTH; i++) begin
            u_host_a.xfer(1'b1, DATA_W'(i), 1'b1, 1'b0);
            if (i == 0 || i == 8) begin
                step();
                check_bit("b_flag", i == 8, b_df);
                check_bit("b_low", 1'b0, b_lf);
                step();
                check_bit("b_flag", 1'b1, b_df);
                check_bit("b_low", i == 8, b_lf);
            end
        end
        repeat (2) step();
        check_bit("a_space", 1'b0, a_sp);
        u_host_a.xfer(1'b1, 36'hf_0000_0000, 1'b1, 1'b0);
        u_host_b.xfer(1'b0, '0, 1'b1, 1'b0);
        step();
        check_word("b_out", 36'h0, b_dout);
        check_bit("a_space", 1'b0, a_sp);
        step();
        check_bit("a_space", 1'b1, a_sp);
        for (int i = 1; i < DEPTH; i++) begin
            u_host_b.xfer(1'b0, '0, 1'b1, 1'b0);
            @(negedge pclk);
            check_word("drain", DATA_W'(i), b_dout);
        end
        repeat (3) step();
        check_bit("b_flag", 1'b0, b_df);
        check_bit("b_low", 1'b0, b_lf);
        do_reset(1'b0);
        apb(1'b0, 12'h004, 32'h0);
        check_word("status", 36'h33, {4'h0, rd});
        u_host_b.xfer(1'b1, 36'h1_2345_6789, 1'b1, 1'b0);
        repeat (2) begin
            step();
            check_bit("a_flag", 1'b0, a_df);
        end
        step();
        check_bit("a_flag", 1'b1, a_df);
        check_word("a_out", 36'h1_2345_6789, a_dout);
        u_host_a.xfer(1'b0, '0, 1'b1, 1'b0);
        step();
        check_bit("a_flag", 1'b0, a_df);
        check_word("a_out", 36'h1_2345_6789, a_dout);
        give_verdict();
    end
endmodule

//--- include/fifo_port_pkg.sv
// Contract
// R01 - First-port data driven only when select and read.
// R02 - First-port qualified write stores into forward queue.
// R03 - First-port qualified read loads return queue output.
// R04 - Each port transfers independently of the other.
// R05 - Second-port direction select has inverted polarity.
// R06 - Second-port qualified write stores into return queue.
// R07 - Second-port qualified read loads forward queue output.
// R08 - Enable low makes select and direction irrelevant.
// R09 - Fall-through loads next word when output-ready rises.
// R10 - Standard mode loads output only on qualified read.
// R11 - Every flag crosses two synchroniser flip-flop stages.
// R12 - Fall-through output-ready low ignores reads, holds word.
// R13 - Standard empty flag low ignores reads, holds word.
// R14 - Pointers advance on each load and write.
// R15 - Fall-through output-ready rises on third read edge.
// R16 - Standard empty flag rises on second read edge.
// R17 - Early read edge may delay first sync cycle.
// R18 - Space flag low means full, writes ignored.
// R19 - Space flag rises on second write edge after read.
// R20 - Early write edge may delay first sync cycle.
// R21 - Low-fill flag high above offset, output word read.
// R22 - Low-fill flag rises on second read edge.
// R23 - Timing mode captured at first edge after reset.
// R24 - Each queue's low-fill flag uses its own offset.
// R25 - Pointers cross between sides in Gray code.
// R26 - Storage is a dual-port memory per queue.
package fifo_port_pkg;

    // ************************************************************
    // Widths and depths.
    // ************************************************************
    localparam int DATA_W  = 36;
    localparam int ADDR_W  = 10;
    localparam int PTR_W   = 11;
    localparam int DEPTH   = 1024;
    localparam int OFF_W   = 10;

    // ************************************************************
    // Register map, field positions and reset values.
    // ************************************************************
    localparam logic [11:0]      OFFSET_ADDR    = 12'h000;
    localparam logic [11:0]      STATUS_ADDR    = 12'h004;
    localparam int               FWD_OFF_LSB    = 0;
    localparam int               RET_OFF_LSB    = 16;
    localparam logic [OFF_W-1:0] FWD_OFF_RESET  = 10'h008;
    localparam logic [OFF_W-1:0] RET_OFF_RESET  = 10'h008;
    localparam int               ST_MODE_BIT    = 0;
    localparam int               ST_TAKEN_BIT   = 1;
    localparam int               ST_FLAGS_LSB   = 4;

    // ************************************************************
    // Pointer code conversions.
    // ************************************************************
    function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = '0;
        b[PTR_W-1] = g[PTR_W-1];
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

//--- rtl/dual_clock_fifo_port_flags.sv
`timescale 1ns/100ps
module dual_clock_fifo_port_flags
    import fifo_port_pkg::*;
(
    // Clock and reset.
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Register bus.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Timing mode strap.
    input  wire logic              endian_timing_select,
    // First port.
    input  wire logic              first_port_select_n,
    input  wire logic              first_port_write_read,
    input  wire logic              first_port_enable,
    input  wire logic              first_port_mail_select,
    input  wire logic [DATA_W-1:0] first_port_data_in,
    output logic      [DATA_W-1:0] first_port_data_out,
    output logic                   first_port_data_oe_n,
    output logic                   first_port_space_flag,
    output logic                   first_port_data_flag,
    output logic                   first_port_low_fill_flag,
    // Second port.
    input  wire logic              second_port_select_n,
    input  wire logic              second_port_write_read_inv,
    input  wire logic              second_port_enable,
    input  wire logic              second_port_mail_select,
    input  wire logic [DATA_W-1:0] second_port_data_in,
    output logic      [DATA_W-1:0] second_port_data_out,
    output logic                   second_port_data_oe_n,
    output logic                   second_port_space_flag,
    output logic                   second_port_data_flag,
    output logic                   second_port_low_fill_flag
);

    // ************************************************************
    // Configuration state.
    // ************************************************************
    logic [OFF_W-1:0] fwd_off_q;
    logic [OFF_W-1:0] ret_off_q;
    logic             fall_through_mode_q;
    logic             mode_taken_q;
    logic [31:0]      prdata_q;

    // Queue index 0 is the forward queue, index 1 the return queue.
    logic [PTR_W-1:0]  wptr_q   [2];
    logic [PTR_W-1:0]  rptr_q   [2];
    logic [PTR_W-1:0]  wgray_q  [2];
    logic [PTR_W-1:0]  rgray_q  [2];
    logic [PTR_W-1:0]  wsync1_q [2];
    logic [PTR_W-1:0]  wsync2_q [2];
    logic [PTR_W-1:0]  rsync1_q [2];
    logic [PTR_W-1:0]  rsync2_q [2];
    logic [DATA_W-1:0] dout_q   [2];
    logic              ready_q  [2];
    logic [DATA_W-1:0] mem      [2][DEPTH];
    logic [DATA_W-1:0] wdata    [2];
    logic [OFF_W-1:0]  offset   [2];
    logic [1:0]        wr_try;
    logic [1:0]        rd_try;
    logic [1:0]        wr_go;
    logic [1:0]        rd_go;
    logic [1:0]        ld;
    logic [1:0]        avail;
    logic [1:0]        space;
    logic [1:0]        data_flag;
    logic [1:0]        low_fill;

    // ************************************************************
    // Timing mode capture.
    // ************************************************************

    // The strap is sampled by the first clock edge after reset release.
    // Low on the strap at that edge picks fall-through timing, high picks
    // standard timing.
    // The choice then stays fixed until the next reset, so the strap may
    // move freely afterwards without disturbing the flags.
    // The captured marker also gates the space flags, which keeps both
    // queues closed to writes until the timing mode is known.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_taken_q        <= 1'b0;
            fall_through_mode_q <= 1'b0;
        end else if (!mode_taken_q) begin
            mode_taken_q        <= 1'b1; // R23
            fall_through_mode_q <= !endian_timing_select; // R23
        end
    end

    // ************************************************************
    // Register bus slave.
    // ************************************************************

    // Writes land in the access phase; zero wait states.
    // Only the offset word is writable; the status word is read only.
    // A write to an unmapped address is dropped and answered with an error; a status write is dropped silently.
    // New offsets act on the low-fill flags at once, so software should
    // change them while the queues are idle to avoid a spurious flag edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_off_q <= FWD_OFF_RESET;
            ret_off_q <= RET_OFF_RESET;
        end else if (psel && penable && pwrite && paddr == OFFSET_ADDR) begin
            fwd_off_q <= pwdata[FWD_OFF_LSB +: OFF_W];
            ret_off_q <= pwdata[RET_OFF_LSB +: OFF_W];
        end
    end

    // Read data is captured in the setup cycle so it leaves a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_q <= 32'h0000_0000;
            if (paddr == OFFSET_ADDR) begin
                prdata_q[FWD_OFF_LSB +: OFF_W] <= fwd_off_q;
                prdata_q[RET_OFF_LSB +: OFF_W] <= ret_off_q;
            end else if (paddr == STATUS_ADDR) begin
                prdata_q[ST_MODE_BIT]        <= fall_through_mode_q;
                prdata_q[ST_TAKEN_BIT]       <= mode_taken_q;
                prdata_q[ST_FLAGS_LSB +: 6]  <= {low_fill, data_flag, space};
            end
        end
    end

    // Unmapped addresses answer with an error in the access phase.
    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && paddr != OFFSET_ADDR && paddr != STATUS_ADDR;

    // ************************************************************
    // Port qualifiers and bus direction.
    // ************************************************************

    // With enable low no transfer is qualified, whatever select shows.
    // Each port builds its own qualifiers from its own pins only, so a
    // transfer on one port never waits for or blocks the other port.
    // Mailbox select high keeps the queue out of the transfer entirely.
    // The second port's direction pin reads the other way round.
    assign wr_try[0] = !first_port_select_n && first_port_write_read
                       && first_port_enable && !first_port_mail_select; // R02 R04 R08
    assign rd_try[1] = !first_port_select_n && !first_port_write_read
                       && first_port_enable && !first_port_mail_select; // R03 R08
    assign wr_try[1] = !second_port_select_n && !second_port_write_read_inv
                       && second_port_enable && !second_port_mail_select; // R05 R06 R08
    assign rd_try[0] = !second_port_select_n && second_port_write_read_inv
                       && second_port_enable && !second_port_mail_select; // R05 R07 R08
    assign wr_go     = wr_try & space; // R18
    assign rd_go     = rd_try & data_flag; // R12 R13

    // Data lines float unless the port is selected for reading.
    assign first_port_data_oe_n  = first_port_select_n || first_port_write_read; // R01
    assign second_port_data_oe_n = second_port_select_n || !second_port_write_read_inv; // R05
    assign first_port_data_out   = dout_q[1];
    assign second_port_data_out  = dout_q[0];
    assign wdata[0]              = first_port_data_in;
    assign wdata[1]              = second_port_data_in;
    assign offset[0]             = fwd_off_q; // R24
    assign offset[1]             = ret_off_q; // R24

    // Flags to pins: forward queue writes at port one, reads at port two.
    assign first_port_space_flag     = space[0];
    assign second_port_data_flag     = data_flag[0];
    assign second_port_low_fill_flag = low_fill[0];
    assign second_port_space_flag    = space[1];
    assign first_port_data_flag      = data_flag[1];
    assign first_port_low_fill_flag  = low_fill[1];

    // ************************************************************
    // Queues.
    // ************************************************************

    // Each queue keeps a binary and a Gray copy of both pointers.
    // Only the Gray copies cross to the far side, through two flip-flops,
    // so a pointer seen mid-change is off by at most one position.
    // A write becomes visible to the read side two edges after it lands.
    // Standard timing raises the data flag on that second edge.
    // Fall-through timing loads the word one edge later, on the third
    // edge, and raises output-ready together with the load.
    // A read becomes visible to the write side two edges after it lands,
    // which is when a full queue shows space again.
    // The pointers carry one spare bit so that full and empty differ.
    for (genvar q = 0; q < 2; q++) begin : g_queue
        logic [PTR_W-1:0] wr_seen;
        logic [PTR_W-1:0] rd_seen;
        logic [PTR_W-1:0] fill;

        // Pointer views taken from the second synchroniser stage only.
        assign wr_seen     = gray2bin(wsync2_q[q]);
        assign rd_seen     = gray2bin(rsync2_q[q]);
        assign fill        = wr_seen - rptr_q[q];
        assign avail[q]    = wr_seen != rptr_q[q]; // R11
        assign space[q]    = mode_taken_q
                             && (wptr_q[q] - rd_seen) != PTR_W'(DEPTH); // R11 R18
        assign low_fill[q] = fill > {1'b0, offset[q]}; // R21 R22
        assign data_flag[q] = fall_through_mode_q ? ready_q[q] : avail[q];
        assign ld[q]       = fall_through_mode_q
                             ? ((!ready_q[q] || rd_go[q]) && avail[q]) // R09
                             : rd_go[q]; // R10

        // Storage array, written on the write side only.
        always_ff @(posedge pclk) begin
            if (wr_go[q]) begin
                mem[q][wptr_q[q][ADDR_W-1:0]] <= wdata[q]; // R26
            end
        end

        // Write pointer in binary and Gray form.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                wptr_q[q]  <= '0;
                wgray_q[q] <= '0;
            end else if (wr_go[q]) begin
                wptr_q[q]  <= wptr_q[q] + 1'b1; // R14
                wgray_q[q] <= bin2gray(wptr_q[q] + 1'b1); // R25
            end
        end

        // Two-stage synchronisers for both pointer directions.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                wsync1_q[q] <= '0;
                wsync2_q[q] <= '0;
                rsync1_q[q] <= '0;
                rsync2_q[q] <= '0;
            end else begin
                wsync1_q[q] <= wgray_q[q]; // R15 R16 R17 R22
                wsync2_q[q] <= wsync1_q[q];
                rsync1_q[q] <= rgray_q[q]; // R19 R20
                rsync2_q[q] <= rsync1_q[q];
            end
        end

        // Read pointer and output register advance together on a load.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                rptr_q[q]  <= '0;
                rgray_q[q] <= '0;
                dout_q[q]  <= '0;
            end else if (ld[q]) begin
                rptr_q[q]  <= rptr_q[q] + 1'b1; // R14
                rgray_q[q] <= bin2gray(rptr_q[q] + 1'b1); // R25
                dout_q[q]  <= mem[q][rptr_q[q][ADDR_W-1:0]];
            end
        end

        // Output-ready rises with a load and falls when a read finds nothing.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ready_q[q] <= 1'b0;
            end else if (ld[q]) begin
                ready_q[q] <= 1'b1; // R09 R15
            end else if (rd_go[q]) begin
                ready_q[q] <= 1'b0;
            end
        end

        // ********************************************************
        // Checks.
        // ********************************************************
        a_write_advance: assert property (@(posedge pclk) disable iff (!presetn) // R14
            wr_go[q] |=> wptr_q[q] == $past(wptr_q[q]) + 1'b1)
            else $error("write pointer did not advance");

        a_full_ignored: assert property (@(posedge pclk) disable iff (!presetn) // R18
            (wr_try[q] && !space[q]) |=> $stable(wptr_q[q]))
            else $error("write accepted while full");

        a_std_empty_lag: assert property (@(posedge pclk) disable iff (!presetn) // R16
            (!fall_through_mode_q && mode_taken_q && wptr_q[q] == rptr_q[q] && wr_go[q])
            |=> !data_flag[q] [*2] ##1 data_flag[q])
            else $error("empty flag not raised on second edge");

        a_fall_through_mode_ready_lag: assert property (@(posedge pclk) disable iff (!presetn) // R15
            (fall_through_mode_q && !ready_q[q] && wptr_q[q] == rptr_q[q] && wr_go[q])
            |=> !ready_q[q] [*3] ##1 (ready_q[q] && dout_q[q] == $past(wdata[q], 4)))
            else $error("output ready not raised with word on third edge");

        a_space_lag: assert property (@(posedge pclk) disable iff (!presetn) // R19
            ((wptr_q[q] - rptr_q[q]) == PTR_W'(DEPTH) && ld[q] && mode_taken_q)
            |=> !space[q] [*2] ##1 space[q])
            else $error("space flag not raised on second edge");

        a_read_advance: assert property (@(posedge pclk) disable iff (!presetn) // R14
            ld[q] |=> rptr_q[q] == $past(rptr_q[q]) + 1'b1)
            else $error("read pointer did not advance on load");

        a_std_hold: assert property (@(posedge pclk) disable iff (!presetn) // R13
            (!fall_through_mode_q && rd_try[q] && !data_flag[q]) |=> $stable(dout_q[q]))
            else $error("output changed on ignored read");

        // A refused fall-through read with nothing available leaves the word and pointer alone.
        a_fall_through_mode_hold: assert property (@(posedge pclk) disable iff (!presetn) // R12
            (fall_through_mode_q && rd_try[q] && !data_flag[q] && !avail[q])
            |=> $stable(dout_q[q]) && $stable(rptr_q[q]))
            else $error("output changed on refused fall-through read");

        // Nothing is ever loaded from an empty store.
        a_load_avail: assert property (@(posedge pclk) disable iff (!presetn) // R14
            ld[q] |-> avail[q])
            else $error("load from empty store");

        // The fill never goes beyond the depth of the store.
        a_fill_bound: assert property (@(posedge pclk) disable iff (!presetn) // R18
            (wptr_q[q] - rptr_q[q]) <= PTR_W'(DEPTH))
            else $error("fill beyond depth");

        // Standard timing loads the output only on a granted read.
        a_std_load: assert property (@(posedge pclk) disable iff (!presetn) // R10
            (!fall_through_mode_q && ld[q]) |-> rd_go[q])
            else $error("standard load without read");

        // No space is offered before the timing mode is captured.
        a_space_mode: assert property (@(posedge pclk) disable iff (!presetn) // R23
            !mode_taken_q |-> !space[q])
            else $error("space offered before mode capture");
    end

    a_mode_hold: assert property (@(posedge pclk) disable iff (!presetn) // R23
        mode_taken_q |=> $stable(fall_through_mode_q) && mode_taken_q)
        else $error("timing mode changed after capture");

    a_first_drive: assert property (@(posedge pclk) disable iff (!presetn) // R01
        first_port_data_oe_n == (first_port_select_n || first_port_write_read))
        else $error("first port drive mismatch");

    a_second_drive: assert property (@(posedge pclk) disable iff (!presetn) // R05
        second_port_data_oe_n == (second_port_select_n || !second_port_write_read_inv))
        else $error("second port drive mismatch");

    // First port enable low grants no transfer at all.
    a_first_idle: assert property (@(posedge pclk) disable iff (!presetn) // R08
        !first_port_enable |-> !wr_go[0] && !rd_go[1])
        else $error("first port transfer with enable low");

    // Second port enable low grants no transfer at all.
    a_second_idle: assert property (@(posedge pclk) disable iff (!presetn) // R08
        !second_port_enable |-> !wr_go[1] && !rd_go[0])
        else $error("second port transfer with enable low");

    // First port mailbox select keeps that port's transfers out of both queues.
    a_first_mail: assert property (@(posedge pclk) disable iff (!presetn) // R02 R03
        first_port_mail_select |-> !wr_go[0] && !rd_go[1])
        else $error("first port queue transfer with mailbox selected");

    // Second port mailbox select keeps that port's transfers out of both queues.
    a_second_mail: assert property (@(posedge pclk) disable iff (!presetn) // R06 R07
        second_port_mail_select |-> !wr_go[1] && !rd_go[0])
        else $error("second port queue transfer with mailbox selected");

endmodule
